// *** psc_pkg.sv ***
// Constants and carriers for the power and processor sideband block
`default_nettype none
package psc_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int MS_DIV = 1000;
   localparam int DEB_MS = 16;
   localparam int OVR_S = 4;
   localparam int SMB_WAIT_MS = 25;
   localparam int PLT_MS = 1;
   localparam int INIT_CLKS = 16;
   localparam int DEB_CYC = DEB_MS * (CLK_HZ / MS_DIV);
   localparam int OVR_CYC = OVR_S * CLK_HZ;
   localparam int SMB_CYC = SMB_WAIT_MS * (CLK_HZ / MS_DIV);
   localparam int PLT_CYC = PLT_MS * (CLK_HZ / MS_DIV);
   localparam int INIT_W = 5;

   typedef struct packed {
      logic power_good;
      logic init_n;
      logic addr20_mask_n;
      logic ignore_fpu_error_n;
      logic nmi;
      logic sys_mgmt_irq_n;
      logic stop_clock_req_n;
      logic deep_sleep_n;
      logic deeper_stop_n;
   } psc_cpu_s;

   localparam psc_cpu_s CPU_RST = '{
      power_good: 1'h0, init_n: 1'h1, addr20_mask_n: 1'h1,
      ignore_fpu_error_n: 1'h1, nmi: 1'h0, sys_mgmt_irq_n: 1'h1,
      stop_clock_req_n: 1'h1, deep_sleep_n: 1'h1, deeper_stop_n: 1'h1};

   typedef enum logic {SR_IDLE, SR_WAIT} psc_sr_e;
endpackage
`default_nettype wire

// *** psc_top.sv ***
// Power-good, reset sequencing and processor sideband logic
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Debounce: level follows input after CYC stable cycles
module psc_debounce #(
   parameter int CYC = psc_pkg::DEB_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_raw_n,
   output logic o_level_n,
   output logic o_press
);
   localparam int W = $clog2(CYC + 1);
   logic [W-1:0] cnt_q;
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         cnt_q <= '0;
         o_level_n <= 1'h1;
         o_press <= 1'h0;
      end
      else
      begin
         o_press <= 1'h0;
         if (i_raw_n == o_level_n)
            cnt_q <= '0;
         else if (cnt_q == W'(CYC - 1))
         begin
            cnt_q <= '0;
            o_level_n <= i_raw_n;
            o_press <= !i_raw_n;
         end
         else
            cnt_q <= cnt_q + 1'h1;
      end
   end
endmodule // psc_debounce

// ==========================================
// Top level
module psc_top #(
   parameter int DEB_CYC = psc_pkg::DEB_CYC,
   parameter int OVR_CYC = psc_pkg::OVR_CYC,
   parameter int SMB_CYC = psc_pkg::SMB_CYC,
   parameter int PLT_CYC = psc_pkg::PLT_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_power_good_input,
   input wire logic i_hub_sync_in,
   input wire logic i_regulator_power_good,
   input wire logic i_link_power_good,
   input wire logic i_resume_well_reset_n,
   input wire logic i_lan_reset_in_n,
   input wire logic i_power_button_in_n,
   input wire logic i_ring_indicate_n,
   input wire logic i_ring_wake_en_wr,
   input wire logic i_ring_wake_en,
   input wire logic i_system_reset_request_n,
   input wire logic i_smbus_idle,
   input wire logic i_sleeping,
   input wire logic i_in_s3_to_s5,
   input wire logic i_sx_transition,
   input wire logic i_sleep_entry,
   input wire logic i_sleep_s3_control_n,
   input wire logic i_battery_low_in_n,
   input wire logic i_battery_low_in_smi_en,
   input wire logic i_smi_event,
   input wire logic i_smi_clr,
   input wire logic i_stop_clock_event,
   input wire logic i_deeper_sleep_req,
   input wire logic i_deep_sleep_req,
   input wire logic i_port92_a20,
   input wire logic i_addr20_gate_in,
   input wire logic i_fpu_error_in_n,
   input wire logic i_fpu_error_report_enable,
   input wire logic i_coproc_err_wr,
   input wire logic i_kbc_reset_in_n,
   input wire logic i_serr,
   input wire logic i_io_check_error,
   input wire logic i_nmi_src_clr,
   output logic o_platform_reset_out_n,
   output logic o_link_reset_out_n,
   output logic o_lan_reset,
   output logic o_suspend_status_out_n,
   output logic o_clockgen_power_good,
   output logic o_deeper_sleep_vr,
   output logic o_irq13,
   output logic o_sleep_request,
   output logic o_wake_event,
   output logic o_force_s5,
   output logic o_internal_reset,
   output logic o_ring_wake_en,
   output var psc_pkg::psc_cpu_s o_cpu
);
   localparam int WP = $clog2(PLT_CYC + 1);
   localparam int WO = $clog2(OVR_CYC + 1);
   localparam int WS = $clog2(SMB_CYC + 1);
   localparam int IW = psc_pkg::INIT_W;
   // ==========================================
   // Decode
   wire pg_int = i_power_good_input & i_hub_sync_in;
   wire pg_all = pg_int & i_regulator_power_good;
   wire btn_lvl_n, btn_press, sr_press;
   logic ring_prev_q, kbc_prev_q, serr_prev_q, io_check_error_prev_q, bat_prev_q;
   logic [WP-1:0] plt_cnt_q, good_run_q;
   logic [WO-1:0] ovr_cnt_q;
   logic [WS-1:0] sr_cnt_q;
   logic [IW-1:0] init_cnt_q;
   logic smi_pend_q, ign_q;
   psc_pkg::psc_sr_e sr_q;
   wire ring_fall = ring_prev_q & !i_ring_indicate_n;
   wire bat_low = !i_battery_low_in_n;
   wire wake_block = bat_low & i_in_s3_to_s5;
   wire ring_wake = ring_fall & o_ring_wake_en & i_sleeping;
   wire fpu_error_in_act = !i_fpu_error_in_n & i_fpu_error_report_enable;
   wire ign_d = fpu_error_in_act & (ign_q | i_coproc_err_wr);
   wire smi_pend_d = (bat_prev_q & bat_low & i_battery_low_in_smi_en) | (smi_pend_q & !i_smi_clr);
   wire kbc_start = kbc_prev_q & !i_kbc_reset_in_n & !i_sx_transition
      & (init_cnt_q == '0);
   wire nmi_set = (!serr_prev_q & i_serr) | (!io_check_error_prev_q & i_io_check_error);

   psc_debounce #(.CYC(DEB_CYC)) u_btn_deb (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_raw_n(i_power_button_in_n), .o_level_n(btn_lvl_n), .o_press(btn_press));
   psc_debounce #(.CYC(DEB_CYC)) u_sr_deb (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_raw_n(i_system_reset_request_n), .o_level_n(), .o_press(sr_press));

   // ==========================================
   // Ring wake enable lives on the resume well, not the main reset
   always_ff @(posedge i_clk)
   begin
      if (!i_resume_well_reset_n)
         o_ring_wake_en <= 1'h0;
      else if (i_ring_wake_en_wr)
         o_ring_wake_en <= i_ring_wake_en;
   end

   // ==========================================
   // Platform reset and system reset request
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         plt_cnt_q <= '0;
         good_run_q <= '0;
         o_platform_reset_out_n <= 1'h0;
      end
      else
      begin
         good_run_q <= !pg_all ? '0 : (good_run_q == WP'(PLT_CYC)) ? good_run_q
            : good_run_q + 1'h1;
         if (!pg_all || o_internal_reset)
         begin
            plt_cnt_q <= '0;
            o_platform_reset_out_n <= 1'h0;
         end
         else if (!o_platform_reset_out_n)
         begin
            plt_cnt_q <= plt_cnt_q + 1'h1;
            o_platform_reset_out_n <= (plt_cnt_q == WP'(PLT_CYC - 1));
         end
      end
   end

   // A busy SMBus gets a bounded grace period so a hung slave cannot block reset
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         sr_q <= psc_pkg::SR_IDLE;
         sr_cnt_q <= '0;
         o_internal_reset <= 1'h0;
      end
      else
      begin
         o_internal_reset <= 1'h0;
         case (sr_q)
            psc_pkg::SR_IDLE:
            begin
               sr_cnt_q <= '0;
               if (sr_press && i_smbus_idle)
                  o_internal_reset <= 1'h1;
               else if (sr_press)
                  sr_q <= psc_pkg::SR_WAIT;
            end
            default:
            begin
               sr_cnt_q <= sr_cnt_q + 1'h1;
               if (i_smbus_idle || sr_cnt_q == WS'(SMB_CYC - 1))
               begin
                  o_internal_reset <= 1'h1;
                  sr_q <= psc_pkg::SR_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Power button, ring, battery
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         ovr_cnt_q <= '0;
         o_force_s5 <= 1'h0;
         o_sleep_request <= 1'h0;
         o_wake_event <= 1'h0;
      end
      else
      begin
         ovr_cnt_q <= btn_lvl_n ? '0 : (ovr_cnt_q == WO'(OVR_CYC)) ? ovr_cnt_q
            : ovr_cnt_q + 1'h1;
         o_force_s5 <= !btn_lvl_n && ovr_cnt_q == WO'(OVR_CYC - 1);
         o_sleep_request <= btn_press & !i_sleeping;
         o_wake_event <= ((btn_press & i_sleeping) | ring_wake) & !wake_block;
      end
   end

   // ==========================================
   // Plain outputs and processor sideband
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         {ring_prev_q, kbc_prev_q, bat_prev_q} <= 3'h7;
         {serr_prev_q, io_check_error_prev_q, smi_pend_q, ign_q} <= 4'h0;
         init_cnt_q <= '0;
         o_link_reset_out_n <= 1'h0;
         o_lan_reset <= 1'h1;
         o_suspend_status_out_n <= 1'h1;
         o_clockgen_power_good <= 1'h0;
         o_deeper_sleep_vr <= 1'h0;
         o_irq13 <= 1'h0;
         o_cpu <= psc_pkg::CPU_RST;
      end
      else
      begin
         ring_prev_q <= i_ring_indicate_n;
         kbc_prev_q <= i_kbc_reset_in_n;
         bat_prev_q <= i_battery_low_in_n;
         serr_prev_q <= i_serr;
         io_check_error_prev_q <= i_io_check_error;
         smi_pend_q <= smi_pend_d;
         ign_q <= ign_d;
         o_link_reset_out_n <= i_link_power_good;
         o_lan_reset <= !i_lan_reset_in_n;
         o_suspend_status_out_n <= !i_sleep_entry;
         o_clockgen_power_good <= i_sleep_s3_control_n & i_regulator_power_good;
         o_deeper_sleep_vr <= i_deeper_sleep_req;
         o_irq13 <= fpu_error_in_act;
         o_cpu.power_good <= pg_all;
         o_cpu.addr20_mask_n <= !(i_port92_a20 | i_addr20_gate_in);
         o_cpu.ignore_fpu_error_n <= !ign_d;
         o_cpu.sys_mgmt_irq_n <= !(i_smi_event | smi_pend_d);
         o_cpu.stop_clock_req_n <= !i_stop_clock_event;
         o_cpu.deep_sleep_n <= !i_deep_sleep_req;
         o_cpu.deeper_stop_n <= !i_deeper_sleep_req;
         o_cpu.nmi <= nmi_set | (o_cpu.nmi & !i_nmi_src_clr);
         if (kbc_start)
         begin
            init_cnt_q <= IW'(psc_pkg::INIT_CLKS);
            o_cpu.init_n <= 1'h0;
         end
         else if (init_cnt_q != '0)
         begin
            init_cnt_q <= init_cnt_q - 1'h1;
            o_cpu.init_n <= (init_cnt_q == IW'(1));
         end
      end
   end

   // ==========================================
   // Assertions
   AST_PLT_ON_POWER_GOOD_INPUT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !pg_int |=> !o_platform_reset_out_n)
      else $error("platform reset not asserted on power good loss");
   AST_PLT_RELEASE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_platform_reset_out_n) |-> good_run_q == WP'(PLT_CYC))
      else $error("platform reset released early");
   AST_LINK_RST: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_link_power_good |=> o_link_reset_out_n)
      else $error("link reset not released");
   AST_CPU_PG: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ##1 o_cpu.power_good == $past(i_power_good_input & i_regulator_power_good & i_hub_sync_in))
      else $error("cpu power good mismatch");
   AST_CKPG: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!i_sleep_s3_control_n || !i_regulator_power_good) |=> !o_clockgen_power_good)
      else $error("clock generator power good high wrongly");
   AST_DEEPER_STOP_N: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_cpu.deeper_stop_n == !o_deeper_sleep_vr)
      else $error("deeper stop is not the inverse of deeper sleep");
   AST_A20: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(i_addr20_gate_in) |=> !o_cpu.addr20_mask_n)
      else $error("address 20 mask missing");
   AST_IGN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !fpu_error_in_act |=> o_cpu.ignore_fpu_error_n)
      else $error("ignore error without fpu error");
   AST_INIT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $fell(o_cpu.init_n) |-> !o_cpu.init_n [*8] ##1 !o_cpu.init_n [*8] ##1 o_cpu.init_n)
      else $error("init pulse not sixteen clocks");
   AST_NMI: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(i_serr) ##1 (!i_nmi_src_clr) [*3] |-> o_cpu.nmi)
      else $error("nmi not held after serr");
   AST_SYSRST: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (sr_press && i_smbus_idle && sr_q == psc_pkg::SR_IDLE) |=> o_internal_reset
      ##1 !o_platform_reset_out_n)
      else $error("system reset not immediate on idle bus");
endmodule // psc_top
`default_nettype wire

// *** psc_far_model.sv ***
// Far-side model: supply rails, regulator and link power sequencing
`timescale 1ns/100ps
`default_nettype none
module psc_far_model #(
   parameter int RSM_CYC = 2
) (
   input wire logic i_clk,
   input wire logic i_on,
   output logic o_power_good_input,
   output logic o_vrm,
   output logic o_link_power_good,
   output logic o_resume_well_reset_n,
   output logic o_lanrst_n
);
   // ==========================================
   // Power-up order: resume wells, LAN and link, then main rails
   int st_q = 0;

   initial {o_power_good_input, o_vrm, o_link_power_good, o_resume_well_reset_n, o_lanrst_n} = 5'h0;

   always @(posedge i_clk)
   begin
      st_q <= i_on ? st_q + 32'(st_q < 9) : 0;
      // Rails drop cleanly; restart takes more than three edges
      if (!i_on)
         {o_power_good_input, o_vrm, o_link_power_good, o_lanrst_n} <= 4'h0;
      else if (st_q == RSM_CYC)
         o_resume_well_reset_n <= 1'h1;
      else if (st_q == RSM_CYC + 2)
         {o_link_power_good, o_lanrst_n} <= 2'h3;
      else if (st_q == RSM_CYC + 5)
         {o_power_good_input, o_vrm} <= 2'h3;
   end
endmodule // psc_far_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the power and processor sideband block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int DEB = 4;
   localparam int OVR = 64;
   localparam int SMB = 16;
   localparam int PLT = 8;
   logic i_clk = 1'h0;
   logic i_reset_n = 1'h0;
   logic on = 1'h0;
   logic power_good_input, vrm, link_power_good, rsm_n, lan_n;
   logic btn_n = 1'h1, ring_n = 1'h1, rwe_wr = 1'h0, rwe = 1'h0, sysr_n = 1'h1, idle = 1'h1;
   logic slp = 1'h0, s3s5 = 1'h0, sxt = 1'h0, sent = 1'h0, s3c_n = 1'h1, bat_n = 1'h1;
   logic bat_en = 1'h0, smi_ev = 1'h0, smi_clr = 1'h0, stp = 1'h0, dpr = 1'h0, dsl = 1'h0;
   logic p92 = 1'h0, a20g = 1'h0, fpu_error_in_n = 1'h1, fpu_error_in_en = 1'h0, cpw = 1'h0, kbc_n = 1'h1;
   logic serr = 1'h0, io_check_error = 1'h0, nclr = 1'h0;
   logic plt_n, lnk_n, lan_reset_in, sus_n, ckpg, dvr, irq13, slp_rq, wake, fs5, irst, rwe_q;
   psc_pkg::psc_cpu_s cpu;
   int cnt[5];
   int n_mismatch = 0;
   int comparisons = 0;

   always #50 i_clk = ~i_clk;

   psc_far_model psc_far_model_i (.i_clk(i_clk), .i_on(on), .o_power_good_input(power_good_input), .o_vrm(vrm),
      .o_link_power_good(link_power_good), .o_resume_well_reset_n(rsm_n), .o_lanrst_n(lan_n));

   psc_top #(.DEB_CYC(DEB), .OVR_CYC(OVR), .SMB_CYC(SMB), .PLT_CYC(PLT)) psc_top_i (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_power_good_input(power_good_input), .i_hub_sync_in(power_good_input),
      .i_regulator_power_good(vrm), .i_link_power_good(link_power_good), .i_resume_well_reset_n(rsm_n),
      .i_lan_reset_in_n(lan_n), .i_power_button_in_n(btn_n), .i_ring_indicate_n(ring_n),
      .i_ring_wake_en_wr(rwe_wr), .i_ring_wake_en(rwe), .i_system_reset_request_n(sysr_n),
      .i_smbus_idle(idle), .i_sleeping(slp), .i_in_s3_to_s5(s3s5), .i_sx_transition(sxt),
      .i_sleep_entry(sent), .i_sleep_s3_control_n(s3c_n), .i_battery_low_in_n(bat_n),
      .i_battery_low_in_smi_en(bat_en), .i_smi_event(smi_ev), .i_smi_clr(smi_clr),
      .i_stop_clock_event(stp), .i_deeper_sleep_req(dpr), .i_deep_sleep_req(dsl),
      .i_port92_a20(p92), .i_addr20_gate_in(a20g), .i_fpu_error_in_n(fpu_error_in_n),
      .i_fpu_error_report_enable(fpu_error_in_en), .i_coproc_err_wr(cpw), .i_kbc_reset_in_n(kbc_n),
      .i_serr(serr), .i_io_check_error(io_check_error), .i_nmi_src_clr(nclr),
      .o_platform_reset_out_n(plt_n), .o_link_reset_out_n(lnk_n), .o_lan_reset(lan_reset_in),
      .o_suspend_status_out_n(sus_n), .o_clockgen_power_good(ckpg), .o_deeper_sleep_vr(dvr),
      .o_irq13(irq13), .o_sleep_request(slp_rq), .o_wake_event(wake), .o_force_s5(fs5),
      .o_internal_reset(irst), .o_ring_wake_en(rwe_q), .o_cpu(cpu));

   // ==========================================
   // Pulse and low-cycle counters, sampled mid-cycle where outputs are settled
   always @(negedge i_clk)
   begin
      cnt[0] += 32'(slp_rq === 1'h1);
      cnt[1] += 32'(wake === 1'h1);
      cnt[2] += 32'(fs5 === 1'h1);
      cnt[4] += 32'(cpu.init_n === 1'h0);
   end

   // ==========================================
   // Tasks
   task automatic chk(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chn(input string nm, input int e, input int g);
      comparisons++;
      if (g != e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic pwr_up;
      @(posedge i_clk);
      on <= 1'h1;
      for (int k = 0; k < 30 && power_good_input !== 1'h1; k++)
         @(negedge i_clk);
      cyc(1);
      chk("cpu_pg", 1'h1, cpu.power_good);
      cyc(PLT - 2);
      chk("plt_early", 1'h0, plt_n);
      cyc(1);
      chk("plt_release", 1'h1, plt_n);
   endtask

   // Holds the button for n edges, then lets the release debounce finish
   task automatic press(input int n);
      @(posedge i_clk);
      btn_n <= 1'h0;
      repeat (n) @(posedge i_clk);
      btn_n <= 1'h1;
      repeat (2 * DEB) @(posedge i_clk);
   endtask

   task automatic sysrst(input logic id, input int lo, input int hi);
      int n;
      n = 0;
      @(posedge i_clk);
      idle <= id;
      sysr_n <= 1'h0;
      while (n < 60 && irst !== 1'h1)
      begin
         @(negedge i_clk);
         n++;
      end
      chk("irst_time", 1'h1, n >= lo && n <= hi);
      cyc(1);
      chk("plt_irst", 1'h0, plt_n);
      @(posedge i_clk);
      sysr_n <= 1'h1;
      idle <= 1'h1;
      repeat (PLT + 2 * DEB + 4) @(posedge i_clk);
   endtask

   task automatic conclude;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ==========================================
   // Tests
   initial
   begin
      cnt = '{default: 0};
      cyc(4);
      chk("rst_plt", 1'h0, plt_n);
      chk("rst_init", 1'h1, cpu.init_n);
      @(posedge i_clk);
      i_reset_n <= 1'h1;
      pwr_up();
      chk("link", 1'h1, lnk_n);
      chk("lan", 1'h0, lan_reset_in);
      chk("ckpg", 1'h1, ckpg);
      @(posedge i_clk);
      s3c_n <= 1'h0;
      cyc(2);
      chk("ckpg_s3", 1'h0, ckpg);
      for (int v = 1; v >= 0; v--)
      begin
         @(posedge i_clk);
         {dpr, dsl, stp, smi_ev, sent} <= {5{1'(v)}};
         cyc(2);
         chk("dvr", 1'(v), dvr);
         chk("dstop", !1'(v), cpu.deeper_stop_n);
         chk("dslp", !1'(v), cpu.deep_sleep_n);
         chk("stop_clock_req", !1'(v), cpu.stop_clock_req_n);
         chk("smi", !1'(v), cpu.sys_mgmt_irq_n);
         chk("sus", !1'(v), sus_n);
      end
      for (int k = 0; k < 4; k++)
      begin
         @(posedge i_clk);
         {p92, a20g} <= 2'(k);
         cyc(2);
         chk("a20", k == 0, cpu.addr20_mask_n);
      end
      @(posedge i_clk);
      {fpu_error_in_en, cpw} <= 2'h3;
      @(posedge i_clk);
      cpw <= 1'h0;
      cyc(2);
      chk("ign_idle", 1'h1, cpu.ignore_fpu_error_n);
      chk("irq13_idle", 1'h0, irq13);
      @(posedge i_clk);
      fpu_error_in_n <= 1'h0;
      cyc(2);
      chk("irq13", 1'h1, irq13);
      @(posedge i_clk);
      cpw <= 1'h1;
      @(posedge i_clk);
      cpw <= 1'h0;
      cyc(1);
      chk("ign", 1'h0, cpu.ignore_fpu_error_n);
      @(posedge i_clk);
      fpu_error_in_n <= 1'h1;
      cyc(2);
      chk("ign_end", 1'h1, cpu.ignore_fpu_error_n);
      @(posedge i_clk);
      {fpu_error_in_en, fpu_error_in_n} <= 2'h0;
      cyc(2);
      chk("irq13_off", 1'h0, irq13);
      for (int s = 0; s < 2; s++)
      begin
         @(posedge i_clk);
         {io_check_error, serr} <= s[0] ? 2'h2 : 2'h1;
         cyc(3);
         chk("nmi", 1'h1, cpu.nmi);
         @(posedge i_clk);
         {io_check_error, serr, nclr} <= 3'h1;
         @(posedge i_clk);
         nclr <= 1'h0;
         cyc(2);
         chk("nmi_clr", 1'h0, cpu.nmi);
      end
      // A second fall inside the pulse must not stretch it
      @(posedge i_clk);
      {fpu_error_in_n, kbc_n} <= 2'h2;
      @(posedge i_clk);
      kbc_n <= 1'h1;
      @(posedge i_clk);
      kbc_n <= 1'h0;
      @(posedge i_clk);
      kbc_n <= 1'h1;
      cyc(30);
      chn("init_len", 16, cnt[4]);
      @(posedge i_clk);
      {sxt, kbc_n} <= 2'h2;
      @(posedge i_clk);
      kbc_n <= 1'h1;
      cyc(30);
      chn("init_sx", 16, cnt[4]);
      @(posedge i_clk);
      sxt <= 1'h0;
      press(20);
      chn("sleep_req", 1, cnt[0]);
      slp <= 1'h1;
      press(20);
      chn("wake_btn", 1, cnt[1]);
      press(OVR + 16);
      chn("force_s5", 1, cnt[2]);
      @(posedge i_clk);
      {rwe_wr, rwe} <= 2'h3;
      @(posedge i_clk);
      {rwe_wr, ring_n} <= 2'h0;
      cyc(2);
      chk("ring_en", 1'h1, rwe_q);
      @(posedge i_clk);
      ring_n <= 1'h1;
      {s3s5, bat_n, bat_en} <= 3'h5;
      cyc(4);
      chn("wake_ring", 3, cnt[1]);
      chk("smi_bat", 1'h0, cpu.sys_mgmt_irq_n);
      press(20);
      chn("wake_blocked", 3, cnt[1]);
      @(posedge i_clk);
      smi_clr <= 1'h1;
      @(posedge i_clk);
      {smi_clr, bat_n, s3s5, slp} <= 4'h4;
      cyc(2);
      chk("smi_clr", 1'h1, cpu.sys_mgmt_irq_n);
      @(posedge i_clk);
      on <= 1'h0;
      cyc(3);
      chk("plt_pwrfail", 1'h0, plt_n);
      chk("cpu_pg_off", 1'h0, cpu.power_good);
      chk("lan_reset_in", 1'h1, lan_reset_in);
      chk("link_off", 1'h0, lnk_n);
      cyc(5);
      chk("ring_keep", 1'h1, rwe_q);
      pwr_up();
      sysrst(1'h1, DEB, DEB + 4);
      sysrst(1'h0, SMB + DEB, SMB + DEB + 4);
      conclude();
   end

   initial
   begin
      repeat (5000) @(posedge i_clk);
      n_mismatch++;
      conclude();
   end
endmodule // tb_top
`default_nettype wire
